// *** design/flash_row_program_erase_control.v ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_defs.vh"
module flash_row_program_erase_control #(
	parameter AW = 16
) (
	input wire core_clk,
	input wire rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire arrayWrValid,
	input wire [AW-1:0] arrayWrAddr,
	input wire [15:0] arrayWrData,
	input wire specialMode,
	input wire lowPowerReq,
	input wire cfgWordUnprot,
	output reg arrayPgmStrobe,
	output reg arrayEraseStrobe,
	output reg eraseBootBlock,
	output reg [AW-1:0] pgmAddr,
	output reg [15:0] pgmData,
	output wire pumpOn,
	output wire programConfig,
	output wire eraseConfig
);
	// Sequencer states
	localparam S_IDLE = 3'd0;
	localparam S_SELECTED = 3'd1;
	localparam S_HV = 3'd2;
	localparam S_READY = 3'd3;
	localparam S_WORD = 3'd4;
	// Enforced waits and the maximum word gap in clock cycles, then row length and boot window bases
	localparam [15:0] SEL_HV = `SEL_HV_CYC;
	localparam [15:0] HV_WR = `HV_WR_CYC;
	localparam [15:0] PGM_MIN = `PGM_MIN_CYC;
	localparam [15:0] PGM_MAX = `PGM_MAX_CYC;
	localparam [5:0] ROW_END = `ROW_WORDS;
	localparam [AW-1:0] BOOT_LO = `BOOT_BASE;
	localparam [AW-1:0] BOOT_HI = `BOOT_BASE_HI;

	reg lock_ff;
	reg bootProt_ff;
	reg unprot_ff;
	reg unprotLoaded_ff;
	reg progSel_ff;
	reg eraseSel_ff;
	reg high_voltage_enable_ff;
	reg swai_ff;
	reg [2:0] state_ff;
	reg [15:0] timer_ff;
	reg [AW-1:0] rowBase_ff;
	reg [5:0] wordCnt_ff;
	reg seqErr_ff;
	reg dWr_ff;
	reg [11:0] dAddr_ff;
	reg [2:0] nxt_state;
	reg [15:0] nxt_timer;
	reg [15:0] wordAge_ff;
	reg [31:0] nxt_rdata;

	// Registers are word-indexed: the byte address is four times the index
	wire [11:0] apIdx = haddr[13:2];
	wire apValid = hsel & hready & htrans[1];
	wire ctlWr = dWr_ff & (dAddr_ff == `OFS_CTRL);
	wire [7:0] wb = hwdata[7:0];
	wire busy = progSel_ff | eraseSel_ff | high_voltage_enable_ff;
	// Setting a select is refused while protected, in special mode as well
	wire allowed = unprot_ff;
	wire abortNow = lowPowerReq;
	// Boot block sits in either 8K window
	wire inBoot = (arrayWrAddr[AW-1:13] == BOOT_HI[AW-1:13]) |
		(arrayWrAddr[AW-1:13] == BOOT_LO[AW-1:13]);
	wire inRow = (arrayWrAddr[AW-1:6] == rowBase_ff[AW-1:6]);
	wire aligned = ~arrayWrAddr[0];
	wire wordTake = (state_ff == S_READY) && (nxt_state == S_WORD);

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign pumpOn = high_voltage_enable_ff;
	assign programConfig = progSel_ff;
	assign eraseConfig = eraseSel_ff;

	// Write address phase is held for the data phase
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dWr_ff <= 1'b0;
			dAddr_ff <= 12'h000;
		end else begin
			dWr_ff <= apValid & hwrite;
			dAddr_ff <= apIdx;
		end
	end

	always @* begin
		case (apIdx)
		`OFS_LOCK: nxt_rdata = {31'h0, lock_ff};
		`OFS_MODCFG: nxt_rdata = {31'h0, bootProt_ff};
		`OFS_CTRL: nxt_rdata = {27'h0, swai_ff, high_voltage_enable_ff, 1'b0, eraseSel_ff,
			progSel_ff};
		`OFS_UNPROT: nxt_rdata = {27'h0, unprot_ff, 4'h0};
		`OFS_STATUS: nxt_rdata = {18'h0, wordCnt_ff, seqErr_ff, 4'h0,
			state_ff};
		default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	// Read data is taken in the address phase and stands in the data phase
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (apValid && !hwrite) begin
			hrdata <= nxt_rdata;
		end
	end

	// Configuration word is sampled on the first edge after reset release
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			unprot_ff <= 1'b0;
			unprotLoaded_ff <= 1'b0;
		end else if (!unprotLoaded_ff) begin
			unprot_ff <= cfgWordUnprot;
			unprotLoaded_ff <= 1'b1;
		end else if (dWr_ff && dAddr_ff == `OFS_UNPROT) begin
			if (specialMode || !wb[`UNPROT_BIT])
				unprot_ff <= wb[`UNPROT_BIT];
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lock_ff <= 1'b0;
			bootProt_ff <= `RST_BOOT_BLOCK_PROTECT;
			swai_ff <= 1'b0;
		end else begin
			if (dWr_ff && dAddr_ff == `OFS_LOCK && (specialMode || !lock_ff))
				lock_ff <= wb[0];
			if (dWr_ff && dAddr_ff == `OFS_MODCFG && !lock_ff && !busy)
				bootProt_ff <= wb[0];
			if (ctlWr)
				swai_ff <= wb[`CTL_SWAI];
		end
	end

	// Select bits and high voltage
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			progSel_ff <= 1'b0;
			eraseSel_ff <= 1'b0;
			high_voltage_enable_ff <= 1'b0;
		end else if (abortNow) begin
			progSel_ff <= 1'b0;
			eraseSel_ff <= 1'b0;
			high_voltage_enable_ff <= 1'b0;
		end else if (ctlWr) begin
			// Setting a select is refused while the other is set or both asked
			if (!wb[`CTL_PROG])
				progSel_ff <= 1'b0;
			else if (!eraseSel_ff && !wb[`CTL_ERASE] && allowed && !high_voltage_enable_ff)
				progSel_ff <= 1'b1;
			if (!wb[`CTL_ERASE])
				eraseSel_ff <= 1'b0;
			else if (!progSel_ff && !wb[`CTL_PROG] && allowed && !high_voltage_enable_ff)
				eraseSel_ff <= 1'b1;
			if (!wb[`CTL_HV])
				high_voltage_enable_ff <= 1'b0;
			else if (state_ff == S_SELECTED && timer_ff == 16'h0 &&
				(progSel_ff || eraseSel_ff))
				high_voltage_enable_ff <= 1'b1;
		end
	end

	// Sequencer: timer counts down the enforced minimum waits
	always @* begin
		nxt_state = state_ff;
		nxt_timer = (timer_ff != 16'h0) ? timer_ff - 16'd1 : 16'h0;
		case (state_ff)
		S_IDLE: begin
			if ((progSel_ff || eraseSel_ff) && arrayWrValid && aligned) begin
				nxt_state = S_SELECTED;
				nxt_timer = SEL_HV;
			end
		end
		S_SELECTED: begin
			if (high_voltage_enable_ff) begin
				nxt_state = progSel_ff ? S_HV : S_READY;
				nxt_timer = HV_WR;
			end
		end
		S_HV: begin
			// A data word arriving before this wait ends is ignored
			if (timer_ff == 16'h0)
				nxt_state = S_READY;
		end
		S_READY: begin
			if (progSel_ff && arrayWrValid && aligned && inRow) begin
				nxt_state = S_WORD;
				nxt_timer = PGM_MIN;
			end
		end
		S_WORD: begin
			if (timer_ff == 16'h0)
				nxt_state = S_READY;
		end
		default: nxt_state = S_IDLE;
		endcase
		if (abortNow || (!progSel_ff && !eraseSel_ff && !high_voltage_enable_ff))
			nxt_state = S_IDLE;
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= S_IDLE;
			timer_ff <= 16'h0;
		end else begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
		end
	end

	// Cycles since the last accepted data word, saturating at the maximum
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wordAge_ff <= 16'h0;
		end else if (wordTake) begin
			wordAge_ff <= 16'h0;
		end else if (wordAge_ff != PGM_MAX) begin
			wordAge_ff <= wordAge_ff + 16'd1;
		end
	end

	// Array strobes; a program strobe can only clear bits
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			arrayPgmStrobe <= 1'b0;
			arrayEraseStrobe <= 1'b0;
			eraseBootBlock <= 1'b0;
			pgmAddr <= {AW{1'b0}};
			pgmData <= 16'hFFFF;
			rowBase_ff <= {AW{1'b0}};
			wordCnt_ff <= 6'h0;
			seqErr_ff <= 1'b0;
		end else begin
			arrayPgmStrobe <= 1'b0;
			arrayEraseStrobe <= 1'b0;
			if (state_ff == S_IDLE && nxt_state == S_SELECTED) begin
				rowBase_ff <= arrayWrAddr;
				wordCnt_ff <= 6'h0;
				seqErr_ff <= 1'b0;
				eraseBootBlock <= ~bootProt_ff;
			end
			if (state_ff == S_SELECTED && nxt_state == S_READY && eraseSel_ff)
				arrayEraseStrobe <= 1'b1;
			if (state_ff == S_READY && nxt_state == S_WORD) begin
				wordCnt_ff <= wordCnt_ff + 6'd1;
				if (!(bootProt_ff && inBoot)) begin
					arrayPgmStrobe <= 1'b1;
					pgmAddr <= arrayWrAddr;
					pgmData <= arrayWrData;
				end
			end
			// Late word: the next word can no longer meet the maximum
			if (progSel_ff && state_ff == S_READY && !wordTake &&
				wordAge_ff == PGM_MAX && wordCnt_ff != 6'h0 &&
				wordCnt_ff != ROW_END)
				seqErr_ff <= 1'b1;
			if (arrayWrValid && progSel_ff && state_ff != S_IDLE &&
				(!aligned || !inRow))
				seqErr_ff <= 1'b1;
		end
	end
endmodule // flash_row_program_erase_control
`default_nettype wire

// *** pkg/flash_ctl_defs.vh ***
`ifndef FLASH_CTL_DEFS_VH
`define FLASH_CTL_DEFS_VH
// Register word indices
`define OFS_LOCK 12'h0F4
`define OFS_MODCFG 12'h0F5
`define OFS_CTRL 12'h0F7
`define OFS_UNPROT 12'h0F0
`define OFS_STATUS 12'h100
// Control register fields
`define CTL_PROG 0
`define CTL_ERASE 1
`define CTL_HV 3
`define CTL_SWAI 4
// Unprotect bit position in the unprotect register
`define UNPROT_BIT 4
// Reset values
`define RST_BOOT_BLOCK_PROTECT 1'b1
// Timing in nanoseconds, clock period in ns
`define CLK_PERIOD_NS 5
`define T_SEL_HV_NS 10000
`define T_HV_WR_NS 5000
`define T_PGM_MIN_NS 30000
`define T_PGM_MAX_NS 40000
`define SEL_HV_CYC ((`T_SEL_HV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HV_WR_CYC ((`T_HV_WR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PGM_MIN_CYC ((`T_PGM_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PGM_MAX_CYC (`T_PGM_MAX_NS / `CLK_PERIOD_NS)
// Array geometry
`define ROW_WORDS 32
`define BOOT_BASE 16'h6000
`define BOOT_TOP 16'h7FFF
`define BOOT_BASE_HI 16'hE000
`endif

// *** tb/flash_ctl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_ctl_props #(parameter AW = 16) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic lowPowerReq,
	input wire logic arrayWrValid,
	input wire logic [AW-1:0] arrayWrAddr,
	input wire logic [15:0] arrayWrData,
	input wire logic arrayPgmStrobe,
	input wire logic arrayEraseStrobe,
	input wire logic [AW-1:0] pgmAddr,
	input wire logic [15:0] pgmData,
	input wire logic pumpOn,
	input wire logic programConfig,
	input wire logic eraseConfig
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence hvUp;
		$rose(pumpOn) && eraseConfig;
	endsequence
	a_cfg_exclusive: assert property (
		!(programConfig && eraseConfig))
		else $error("both selects active");
	a_hv_needs_sel: assert property (
		$rose(pumpOn) |-> programConfig || eraseConfig)
		else $error("pump on without select");
	a_lowpwr_abort: assert property (
		lowPowerReq |=> !(pumpOn || programConfig || eraseConfig))
		else $error("low power did not abort");
	a_pgm_cause: assert property (
		arrayPgmStrobe |-> $past(arrayWrValid) && pumpOn)
		else $error("program strobe without cause");
	a_pgm_latch: assert property (
		arrayPgmStrobe |-> pgmAddr == $past(arrayWrAddr) &&
		pgmData == $past(arrayWrData))
		else $error("program word not latched");
	a_pgm_pulse: assert property (
		arrayPgmStrobe |=> !arrayPgmStrobe)
		else $error("program strobe too long");
	a_erase_start: assert property (
		hvUp |-> ##[0:1] arrayEraseStrobe)
		else $error("erase did not start");
	a_erase_pulse: assert property (
		arrayEraseStrobe |=> !arrayEraseStrobe)
		else $error("erase strobe too long");
endmodule // flash_ctl_props
bind flash_row_program_erase_control flash_ctl_props #(.AW(AW)) u_props (
	.core_clk(core_clk), .rst(rst), .lowPowerReq(lowPowerReq),
	.arrayWrValid(arrayWrValid), .arrayWrAddr(arrayWrAddr),
	.arrayWrData(arrayWrData), .arrayPgmStrobe(arrayPgmStrobe),
	.arrayEraseStrobe(arrayEraseStrobe), .pgmAddr(pgmAddr),
	.pgmData(pgmData), .pumpOn(pumpOn), .programConfig(programConfig),
	.eraseConfig(eraseConfig));
`default_nettype wire

// *** tb/test_flash_row_program_erase_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_defs.vh"
module test_flash_row_program_erase_control;
	localparam logic [31:0] CTRL = `OFS_CTRL * 32'h4;
	localparam logic [31:0] MCFG = `OFS_MODCFG * 32'h4;
	localparam logic [31:0] UNPR = `OFS_UNPROT * 32'h4;
	localparam logic [31:0] STAT = `OFS_STATUS * 32'h4;
	logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, arrayWrValid = 0;
	logic specialMode = 0, lowPowerReq = 0, cfgWordUnprot = 1;
	logic [31:0] haddr = 0, hwdata = 0, q, miscompares = 0, totalChecks = 0;
	logic [31:0] pgmCnt = 0, erCnt = 0, lastPgm = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [15:0] awA = 0, awD = 0;
	wire [31:0] hrdata;
	wire [15:0] pgmAddr, pgmData;
	wire hreadyout, hresp, arrayPgmStrobe, arrayEraseStrobe, eraseBootBlock;
	wire pumpOn, programConfig, eraseConfig;
	flash_row_program_erase_control u_dut (.core_clk(core_clk), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .arrayWrValid(arrayWrValid),
		.arrayWrAddr(awA), .arrayWrData(awD), .specialMode(specialMode),
		.lowPowerReq(lowPowerReq), .cfgWordUnprot(cfgWordUnprot),
		.arrayPgmStrobe(arrayPgmStrobe), .arrayEraseStrobe(arrayEraseStrobe),
		.eraseBootBlock(eraseBootBlock), .pgmAddr(pgmAddr), .pgmData(pgmData),
		.pumpOn(pumpOn), .programConfig(programConfig),
		.eraseConfig(eraseConfig));
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (arrayPgmStrobe === 1'h1) begin
			pgmCnt <= pgmCnt + 1;
			lastPgm <= {pgmAddr, pgmData};
		end
		if (arrayEraseStrobe === 1'h1)
			erCnt <= erCnt + 1;
	end
	task results;
		if (miscompares == 0 && totalChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge core_clk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'h1);
		q = hrdata;
		hsel <= 0;
	endtask
	task aw(input logic [15:0] a, input logic [15:0] d);
		@(posedge core_clk);
		arrayWrValid <= 1;
		awA <= a;
		awD <= d;
		@(posedge core_clk);
		arrayWrValid <= 0;
	endtask
	task pass(input logic [15:0] a, input logic [15:0] d, input logic [31:0] n);
		bus(CTRL, 1, 32'h1);
		aw(a, 16'hFFFF);
		repeat (`SEL_HV_CYC) @(posedge core_clk);
		bus(CTRL, 1, 32'h9);
		repeat (`HV_WR_CYC + 4) @(posedge core_clk);
		aw(a, d);
		repeat (`PGM_MIN_CYC) @(posedge core_clk);
		chk(pgmCnt, n);
		bus(STAT, 0, 32'h0);
		chk(q[13:7], 7'h02);
		bus(CTRL, 1, 32'h8);
		repeat (`HV_WR_CYC) @(posedge core_clk);
		bus(CTRL, 1, 32'h0);
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 0;
		bus(UNPR, 0, 32'h0);
		chk(q[`UNPROT_BIT], 1);
		bus(MCFG, 0, 32'h0);
		chk(q[0], `RST_BOOT_BLOCK_PROTECT);
		bus(CTRL, 1, 32'h3);
		#1 chk({programConfig, eraseConfig}, 0);
		bus(CTRL, 1, 32'h1);
		bus(CTRL, 1, 32'h9);
		#1 chk({programConfig, pumpOn}, 2'h2);
		bus(MCFG, 1, 32'h0);
		bus(MCFG, 0, 32'h0);
		chk(q[0], 1);
		pass(16'h1040, 16'hA5C3, 1);
		chk(lastPgm, 32'h1040A5C3);
		pass(`BOOT_BASE, 16'h1234, 1);
		bus(CTRL, 1, 32'h2);
		aw(16'h2000, 16'h0);
		repeat (`SEL_HV_CYC) @(posedge core_clk);
		bus(CTRL, 1, 32'hA);
		repeat (3) @(posedge core_clk);
		chk({erCnt[3:0], eraseBootBlock}, 5'h02);
		lowPowerReq <= 1;
		repeat (2) @(posedge core_clk);
		#1 chk({pumpOn, eraseConfig}, 0);
		lowPowerReq <= 0;
		bus(MCFG, 1, 32'h0);
		bus(MCFG, 0, 32'h0);
		chk(q[0], 0);
		bus(CTRL, 1, 32'h2);
		aw(16'h2000, 16'h0);
		#1 chk(eraseBootBlock, 1);
		bus(CTRL, 1, 32'h0);
		bus(UNPR, 1, 32'h0);
		bus(UNPR, 1, 32'h10);
		bus(UNPR, 0, 32'h0);
		chk(q[`UNPROT_BIT], 0);
		bus(CTRL, 1, 32'h1);
		#1 chk(programConfig, 0);
		specialMode <= 1;
		bus(UNPR, 1, 32'h10);
		bus(UNPR, 0, 32'h0);
		chk(q[`UNPROT_BIT], 1);
		bus(32'h800, 0, 32'h0);
		chk(q, 0);
		chk(hresp, 0);
		results;
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		miscompares++;
		results;
	end
endmodule // test_flash_row_program_erase_control
`default_nettype wire
